// >>> logic/mit_core.sv
// Instruction execution timing, flag update and table read unit of the core.
//
// How it works
// - Moves take one cycle, flags untouched.
// - Bit clear or set: one cycle, no flags.
// - Jump, call and returns take two cycles.
// - Standard skip: one cycle, up to three skipping.
// - Standard write to counter low: two cycles.
// - Watchdog clear clears timeout and powerdown flags.
// - Halt enters power down, updates both flags.
// - Table read: two cycles, high byte, low byte.
// - Last-page variants read from the last page.
// - Nibble exchange, one cycle, memory or accumulator.
// - Extended forms reach the full data range.
// - Extended forms take two cycles, same flags.
// - Extended subtracts update six arithmetic flags.
// - Extended table reads take three cycles.
// - Extended skip: two cycles, up to four.
// - Extended write to counter low: three cycles.
// - Increment or decrement skip on zero result.
// - Skip-zero-move copies byte, skips when zero.
// - Carry rotates change carry only; plain none.
// - Extended decimal adjust: memory result, carry only.
// - Logic and complement change only zero flag.
// - Bit-nonzero skip skips when bit is one.
// - Carry on overflow past 255, clear on borrow.
// - Branch continues or skips the next instruction.
`timescale 1ns/1ps
`default_nettype none

module mit_core
	import mit_pkg::*;
(
	input  wire logic              ref_clk,          // 50 MHz instruction clock.
	input  wire logic              sys_rst,          // Synchronous reset, active high.
	input  wire logic [7:0]        reg_addr,         // Register byte address.
	input  wire logic [31:0]       reg_wdata,        // Register write data.
	input  wire logic              reg_wr,           // Register write strobe.
	input  wire logic              reg_rd,           // Register read strobe.
	output logic      [31:0]       reg_rdata,        // Read data, cycle after the strobe.
	input  wire logic              ins_valid,        // Decoded instruction offered.
	input  wire mit_ins_s          ins,              // Decoded instruction and operands.
	output logic                   ins_ready,        // Core can take an offered instruction this cycle.
	input  wire logic [PAGE_W-1:0] cur_page,         // Page of the running program.
	output logic                   pm_rd,            // Program memory read pulse.
	output logic      [PM_AW-1:0]  pm_addr,          // Program memory word address.
	input  wire logic [15:0]       pm_data,          // Word, taken while the pulse stands.
	output mit_dmw_s               dm_wr,            // Data memory write pulse.
	output logic      [7:0]        accumulator_reg,  // Accumulator contents.
	output mit_flags_s             status_flags,     // Status flags.
	output logic      [7:0]        table_pointer,    // Table pointer.
	output logic      [7:0]        table_high_byte,  // High byte of the last table word.
	output logic                   skip_pending,     // Next instruction will be discarded.
	output logic                   powerdown_mode    // Core is in power down.
);

	typedef struct packed {
		mit_fsm_e         fsm;
		logic [2:0]       cnt;
		logic [7:0]       accum;
		mit_flags_s       flags;
		logic [7:0]       tptr;
		logic [7:0]       thigh;
		logic [15:0]      tdata;
		logic             tbl_busy;
		logic [DM_AW-1:0] tbl_addr;
		logic             skip;
		logic             pdown;
		mit_dmw_s         dmw;
		logic             pm_rd;
		logic [PM_AW-1:0] pm_addr;
		logic [31:0]      rdata;
	} mit_core_s;

	mit_core_s  q;
	mit_core_s  d;
	logic       issue;
	logic [2:0] need;
	logic [7:0] opnd;
	logic [7:0] bv;
	logic       cin;
	logic       sub;
	logic [8:0] sum9;
	logic [7:0] low8;
	logic [4:0] lo5;
	logic [8:0] daa9;
	logic [7:0] res;
	logic       res_wr;
	logic       res_to_a;
	logic       skp;
	mit_flags_s nf;
	mit_flags_s wf;
	logic [7:0] tptr_n;
	logic [15:0] tword;
	logic [31:0] stv;

	// ----------------------------------------------------------------
	// Cycle count of an instruction
	// ----------------------------------------------------------------
	// Returns the total cycles an issued instruction occupies the core.
	function automatic logic [2:0] cyc_of(input mit_ins_s i, input logic discard);
		logic [2:0] n;
		n = i.ext ? CYC_EXT : CYC_STD;
		if (discard)
			n = i.ext ? CYC_EXT : CYC_STD;
		else
			case (i.op)
				OP_JMP, OP_CALL, OP_RET, OP_RET_IMM, OP_RET_INT:
					n = CYC_BRANCH;
				OP_TBL_READ:
					n = i.ext ? CYC_TBL_EXT : CYC_TBL_STD;
				default:
					if (i.to_pcl)
						n = i.ext ? CYC_PCL_EXT : CYC_PCL_STD;
			endcase
		return n;
	endfunction

	// Issue is allowed only when idle and awake, so results settle first.
	assign ins_ready = (q.fsm == S_IDLE) && !q.pdown;
	assign issue     = ins_valid && ins_ready;
	assign need      = cyc_of(ins, q.skip);

	// ----------------------------------------------------------------
	// Result and flag computation
	// ----------------------------------------------------------------
	// Works out the result byte, its destination, the new flags and the skip.
	always_comb
	begin
		opnd     = ins.use_imm ? ins.imm : ins.mem_data;
		sub      = (ins.op == OP_SUB) || (ins.op == OP_SBC);
		bv       = sub ? ~opnd : opnd;
		cin      = (ins.op == OP_SUB) || ((ins.op != OP_ADD) && q.flags.carry_flag);
		sum9     = {1'b0, q.accum} + {1'b0, bv} + {8'h00, cin};
		low8     = {1'b0, q.accum[6:0]} + {1'b0, bv[6:0]} + {7'h00, cin};
		lo5      = {1'b0, q.accum[3:0]} + {1'b0, bv[3:0]} + {4'h0, cin};
		daa9     = {1'b0, q.accum};
		nf       = q.flags;
		res      = 8'h00;
		res_wr   = 1'b1;
		res_to_a = ins.to_accum;
		skp      = 1'b0;
		case (ins.op)
			OP_ADD, OP_ADC, OP_SUB, OP_SBC:
			begin
				res               = sum9[7:0];
				nf.carry_flag     = sum9[8];
				nf.aux_carry_flag = lo5[4];
				nf.overflow_flag  = low8[7] ^ sum9[8];
				nf.zero_flag      = (sum9[7:0] == 8'h00);
				nf.signed_flag    = low8[7] ^ sum9[8] ^ sum9[7];
				if (sub)
					nf.carry_zero_flag = (ins.op == OP_SUB) ? nf.zero_flag :
						(nf.zero_flag && q.flags.carry_zero_flag);
			end
			OP_DAA:
			begin
				if ((q.accum[3:0] > 4'h9) || q.flags.aux_carry_flag)
					daa9 = daa9 + 9'h006;
				if ((daa9[8:4] > 5'h09) || q.flags.carry_flag)
					daa9 = daa9 + 9'h060;
				res           = daa9[7:0];
				res_to_a      = 1'b0;
				nf.carry_flag = daa9[8] || q.flags.carry_flag;
			end
			OP_AND, OP_OR, OP_XOR, OP_CPL:
			begin
				case (ins.op)
					OP_AND:  res = q.accum & opnd;
					OP_OR:   res = q.accum | opnd;
					OP_XOR:  res = q.accum ^ opnd;
					default: res = ~ins.mem_data;
				endcase
				nf.zero_flag = (res == 8'h00);
			end
			OP_INC, OP_DEC:
			begin
				res          = (ins.op == OP_INC) ? ins.mem_data + 8'h01 : ins.mem_data - 8'h01;
				nf.zero_flag = (res == 8'h00);
			end
			OP_RR:   res = {ins.mem_data[0], ins.mem_data[7:1]};
			OP_RL:   res = {ins.mem_data[6:0], ins.mem_data[7]};
			OP_RRC:
			begin
				res           = {q.flags.carry_flag, ins.mem_data[7:1]};
				nf.carry_flag = ins.mem_data[0];
			end
			OP_RLC:
			begin
				res           = {ins.mem_data[6:0], q.flags.carry_flag};
				nf.carry_flag = ins.mem_data[7];
			end
			OP_MOVA:
			begin
				res      = opnd;
				res_to_a = 1'b1;
			end
			OP_MOVM:
			begin
				res      = q.accum;
				res_to_a = 1'b0;
			end
			OP_BCLR, OP_BSET:
			begin
				res              = ins.mem_data;
				res[ins.bit_idx] = (ins.op == OP_BSET);
				res_to_a         = 1'b0;
			end
			OP_CLRM:  res = 8'h00;
			OP_SETM:  res = 8'hff;
			OP_SWAP:  res = {ins.mem_data[3:0], ins.mem_data[7:4]};
			OP_SZ:
			begin
				res_wr = 1'b0;
				skp    = (ins.mem_data == 8'h00);
			end
			OP_SNZ:
			begin
				res_wr = 1'b0;
				skp    = (ins.mem_data != 8'h00);
			end
			OP_SZB, OP_SNZB:
			begin
				res_wr = 1'b0;
				skp    = ins.mem_data[ins.bit_idx] == (ins.op == OP_SNZB);
			end
			OP_SKZ_MOVE:
			begin
				res      = ins.mem_data;
				res_to_a = 1'b1;
				skp      = (ins.mem_data == 8'h00);
			end
			OP_SIZ, OP_SDZ:
			begin
				res = (ins.op == OP_SIZ) ? ins.mem_data + 8'h01 : ins.mem_data - 8'h01;
				skp = (res == 8'h00);
			end
			OP_RET_IMM:
			begin
				res      = ins.imm;
				res_to_a = 1'b1;
			end
			OP_WDT_CLR:
			begin
				res_wr            = 1'b0;
				nf.timeout_flag   = 1'b0;
				nf.powerdown_flag = 1'b0;
			end
			OP_HALT:
			begin
				res_wr            = 1'b0;
				nf.timeout_flag   = 1'b0;
				nf.powerdown_flag = 1'b1;
			end
			default: res_wr = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// Register writes first, then execution, so execution wins a clash.
	always_comb
	begin
		d                    = q;
		d.dmw.we             = 1'b0;
		d.pm_rd              = 1'b0;
		d.rdata              = 32'h00000000;
		wf                   = mit_flags_s'(reg_wdata[7:0]);
		wf.timeout_flag      = q.flags.timeout_flag;
		wf.powerdown_flag    = q.flags.powerdown_flag;
		tptr_n               = ins.preinc ? q.tptr + 8'h01 : q.tptr;
		tword                = q.pm_rd ? pm_data : q.tdata;
		stv                  = 32'h00000000;
		stv[ST_BUSY]         = (q.fsm != S_IDLE);
		stv[ST_SKIP]         = q.skip;
		stv[ST_PDOWN]        = q.pdown;
		if (q.pm_rd)
			d.tdata = pm_data;
		if (reg_wr)
			case (reg_addr)
				OFS_ACCUM:  d.accum = reg_wdata[7:0];
				OFS_STATUS: d.flags = wf;
				OFS_TPTR:   d.tptr  = reg_wdata[7:0];
				OFS_STATE:  d.pdown = q.pdown && !reg_wdata[ST_PDOWN];
				default:    d.rdata = 32'h00000000;
			endcase
		case (q.fsm)
			S_IDLE:
				if (issue)
				begin
					d.skip = 1'b0;
					if (!q.skip)
					begin
						d.flags = nf;
						d.skip  = skp;
						if (res_wr && res_to_a)
							d.accum = res;
						else if (res_wr)
							d.dmw = '{we: 1'b1, addr: ins.addr, data: res};
						if (ins.op == OP_HALT)
							d.pdown = 1'b1;
						if (ins.op == OP_TBL_READ)
						begin
							d.tptr     = tptr_n;
							d.pm_rd    = 1'b1;
							d.pm_addr  = {(ins.last_page ? LAST_PAGE : cur_page), tptr_n};
							d.tbl_busy = 1'b1;
							d.tbl_addr = ins.addr;
						end
					end
					if (need > 3'h1)
					begin
						d.fsm = S_WAIT;
						d.cnt = need - 3'h2;
					end
				end
			S_WAIT:
				if (q.cnt == 3'h0)
				begin
					d.fsm = S_IDLE;
					if (q.tbl_busy)
					begin
						d.tbl_busy = 1'b0;
						d.thigh    = tword[15:8];
						d.dmw      = '{we: 1'b1, addr: q.tbl_addr, data: tword[7:0]};
					end
				end
				else
					d.cnt = q.cnt - 3'h1;
			default: d.fsm = S_IDLE;
		endcase
		if (reg_rd)
			case (reg_addr)
				OFS_ACCUM:  d.rdata = {24'h000000, q.accum};
				OFS_STATUS: d.rdata = {24'h000000, q.flags};
				OFS_TPTR:   d.rdata = {24'h000000, q.tptr};
				OFS_THIGH:  d.rdata = {24'h000000, q.thigh};
				OFS_STATE:  d.rdata = stv;
				default:    d.rdata = 32'h00000000;
			endcase
	end

	// State register.
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			q       <= '0;
			q.accum <= RST_ACCUM;
			q.flags <= mit_flags_s'(RST_FLAGS);
			q.tptr  <= RST_TPTR;
			q.thigh <= RST_THIGH;
		end
		else
			q <= d;
	end

	// Outputs straight from the state register.
	assign reg_rdata       = q.rdata;
	assign pm_rd           = q.pm_rd;
	assign pm_addr         = q.pm_addr;
	assign dm_wr           = q.dmw;
	assign accumulator_reg = q.accum;
	assign status_flags    = q.flags;
	assign table_pointer   = q.tptr;
	assign table_high_byte = q.thigh;
	assign skip_pending    = q.skip;
	assign powerdown_mode  = q.pdown;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	// Timing and flag checks on issued instructions.
	a_mov_one_cycle: assert property (issue && !q.skip && ins.op == OP_MOVA && !ins.ext
		&& !ins.to_pcl |=> ins_ready && $stable(status_flags))
		else $error("move did not finish in one cycle with flags kept");
	a_bit_op_flags: assert property (issue && !q.skip && !ins.ext && !ins.to_pcl
		&& (ins.op == OP_BCLR || ins.op == OP_BSET)
		|=> ins_ready && dm_wr.we && $stable(status_flags))
		else $error("bit operation timing or flags wrong");
	a_branch_two_cyc: assert property (issue && !q.skip && (ins.op == OP_JMP
		|| ins.op == OP_CALL || ins.op == OP_RET || ins.op == OP_RET_INT)
		|=> !ins_ready ##1 ins_ready)
		else $error("branch did not take two cycles");
	a_pcl_std_two: assert property (issue && !q.skip && !ins.ext && ins.to_pcl
		|=> !ins_ready ##1 ins_ready)
		else $error("counter low write did not take two cycles");
	a_pcl_ext_three: assert property (issue && !q.skip && ins.ext && ins.to_pcl
		&& ins.op == OP_MOVM |=> !ins_ready [*2] ##1 ins_ready)
		else $error("extended counter low write did not take three cycles");
	a_wdt_clear: assert property (issue && !q.skip && ins.op == OP_WDT_CLR
		|=> !status_flags.timeout_flag && !status_flags.powerdown_flag)
		else $error("watchdog clear left a flag set");
	a_halt_enter: assert property (issue && !q.skip && ins.op == OP_HALT
		|=> powerdown_mode && status_flags.powerdown_flag && !ins_ready)
		else $error("halt did not enter power down");
	a_tbl_std_time: assert property (issue && !q.skip && ins.op == OP_TBL_READ && !ins.ext
		|=> pm_rd && !ins_ready ##1 ins_ready && dm_wr.we)
		else $error("table read did not finish in two cycles");
	a_tbl_ext_time: assert property (issue && !q.skip && ins.op == OP_TBL_READ && ins.ext
		|=> !ins_ready [*2] ##1 ins_ready && dm_wr.we)
		else $error("extended table read did not finish in three cycles");
	a_tbl_last_page: assert property (issue && !q.skip && ins.op == OP_TBL_READ
		&& ins.last_page |=> pm_addr[PM_AW-1:8] == LAST_PAGE)
		else $error("last page table read used the wrong page");
	a_skip_discard: assert property (issue && q.skip && !reg_wr
		|=> $stable(accumulator_reg) && $stable(status_flags) && !dm_wr.we
		&& !skip_pending)
		else $error("discarded instruction had an effect");
	a_sub_borrow: assert property (issue && !q.skip && ins.op == OP_SUB && !ins.use_imm
		&& ins.mem_data > q.accum |=> !status_flags.carry_flag)
		else $error("borrow not shown on carry");

	// Main scenarios reached.
	c_ext_skip_taken: cover property (issue && ins.ext && ins.op == OP_SZ
		&& ins.mem_data == 8'h00 ##2 issue && q.skip);
	c_tbl_ext_last: cover property (issue && ins.op == OP_TBL_READ && ins.ext
		&& ins.last_page && ins.preinc);
	c_halt_wake: cover property (powerdown_mode ##1 !powerdown_mode);
	c_daa_carry: cover property (issue && ins.op == OP_DAA ##1 status_flags.carry_flag);

endmodule

`default_nettype wire

// >>> logic/mit_pkg.sv
// Shared types, register offsets and cycle counts of the instruction timing unit.
package mit_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int unsigned DM_AW  = 11;  // Data memory address, all sections.
	localparam int unsigned PAGE_W = 7;   // Program memory page number.
	localparam int unsigned PM_AW  = 15;  // Program memory word address.

	// ----------------------------------------------------------------
	// Register offsets, state bits and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_ACCUM  = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_TPTR   = 8'h08;
	localparam logic [7:0] OFS_THIGH  = 8'h0c;
	localparam logic [7:0] OFS_STATE  = 8'h10;
	localparam int unsigned ST_BUSY   = 0;
	localparam int unsigned ST_SKIP   = 1;
	localparam int unsigned ST_PDOWN  = 2;
	localparam logic [7:0] RST_ACCUM  = 8'h00;
	localparam logic [7:0] RST_FLAGS  = 8'h00;
	localparam logic [7:0] RST_TPTR   = 8'h00;
	localparam logic [7:0] RST_THIGH  = 8'h00;
	localparam logic [PAGE_W-1:0] LAST_PAGE = 7'h7f;

	// ----------------------------------------------------------------
	// Instruction cycle counts
	// ----------------------------------------------------------------
	localparam logic [2:0] CYC_STD     = 3'h1;
	localparam logic [2:0] CYC_EXT     = 3'h2;
	localparam logic [2:0] CYC_BRANCH  = 3'h2;
	localparam logic [2:0] CYC_TBL_STD = 3'h2;
	localparam logic [2:0] CYC_TBL_EXT = 3'h3;
	localparam logic [2:0] CYC_PCL_STD = 3'h2;
	localparam logic [2:0] CYC_PCL_EXT = 3'h3;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [5:0] {
		OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_DAA, OP_AND, OP_OR, OP_XOR, OP_CPL,
		OP_INC, OP_DEC, OP_RR, OP_RRC, OP_RL, OP_RLC, OP_MOVA, OP_MOVM, OP_BCLR, OP_BSET,
		OP_CLRM, OP_SETM, OP_SWAP, OP_SZ, OP_SKZ_MOVE, OP_SZB, OP_SNZ, OP_SNZB, OP_SIZ,
		OP_SDZ, OP_JMP, OP_CALL, OP_RET, OP_RET_IMM, OP_RET_INT, OP_TBL_READ, OP_WDT_CLR,
		OP_HALT
	} mit_op_e;

	typedef enum logic {S_IDLE, S_WAIT} mit_fsm_e;

	typedef struct packed {
		logic carry_zero_flag;
		logic signed_flag;
		logic timeout_flag;
		logic powerdown_flag;
		logic overflow_flag;
		logic zero_flag;
		logic aux_carry_flag;
		logic carry_flag;
	} mit_flags_s;

	typedef struct packed {
		mit_op_e          op;
		logic             ext;        // Extended long-address form.
		logic             to_accum;   // Result goes to the accumulator.
		logic             use_imm;    // Operand is the immediate byte.
		logic             last_page;  // Table read from the last page.
		logic             preinc;     // Table pointer advances first.
		logic             to_pcl;     // Destination byte is the counter low byte.
		logic [DM_AW-1:0] addr;
		logic [7:0]       mem_data;
		logic [7:0]       imm;
		logic [2:0]       bit_idx;
	} mit_ins_s;

	typedef struct packed {
		logic             we;
		logic [DM_AW-1:0] addr;
		logic [7:0]       data;
	} mit_dmw_s;

endpackage

// >>> tb/mit_core_tb_top.sv
// Self-checking bench for the instruction timing and flag unit.
`timescale 1ns/1ps
`default_nettype none

module mit_core_tb_top
	import mit_pkg::*;
;
	typedef struct {
		mit_ins_s   i;
		logic [7:0] a0, a1, f0, f1, wd;
		logic       we, sk;
		int         cyc;
	} mit_row_s;

	logic             ref_clk = 1'b0;
	logic             sys_rst = 1'b1;
	logic [7:0]       reg_addr = 8'h00;
	logic [31:0]      reg_wdata = 32'h0;
	logic             reg_wr = 1'b0;
	logic             reg_rd = 1'b0;
	logic             ins_valid = 1'b0;
	mit_ins_s         ins = '0;
	logic [6:0]       cur_page = 7'h15;
	logic [31:0]      reg_rdata, v;
	logic             ins_ready, pm_rd, skip_pending, powerdown_mode;
	logic [PM_AW-1:0] pm_addr;
	logic [15:0]      pm_data;
	mit_dmw_s         dm_wr, wr_last;
	mit_flags_s       status_flags;
	logic [7:0]       accumulator_reg, table_pointer, table_high_byte, ptr;
	int               fail_count = 0, checks = 0, tick = 0, wr_n = 0, n, n0;
	mit_row_s         rows[$];
	mit_row_s         t;

	// Clock at 50 MHz.
	always #10 ref_clk = ~ref_clk;

	mit_core dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ins_valid(ins_valid), .ins(ins), .ins_ready(ins_ready), .cur_page(cur_page),
		.pm_rd(pm_rd), .pm_addr(pm_addr), .pm_data(pm_data), .dm_wr(dm_wr),
		.accumulator_reg(accumulator_reg), .status_flags(status_flags),
		.table_pointer(table_pointer), .table_high_byte(table_high_byte),
		.skip_pending(skip_pending), .powerdown_mode(powerdown_mode));

	mit_pm_model pmem (.ref_clk(ref_clk), .pm_rd(pm_rd), .pm_addr(pm_addr), .pm_data(pm_data));

	// Counts data memory write pulses and keeps the last one; also cuts a hang short.
	always @(posedge ref_clk)
	begin
		if (dm_wr.we === 1'b1)
		begin
			wr_n <= wr_n + 1;
			wr_last <= dm_wr;
		end
		tick <= tick + 1;
		if (tick == 4000)
		begin
			fail_count++;
			conclude();
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask

	// Issues one instruction and counts cycles until the core is ready again.
	task automatic run(input mit_row_s x, output int c);
		@(posedge ref_clk);
		ins_valid <= 1'b1;
		ins <= x.i;
		@(posedge ref_clk);
		ins_valid <= 1'b0;
		c = 1;
		@(negedge ref_clk);
		while (ins_ready !== 1'b1 && c < 10)
		begin
			c++;
			@(negedge ref_clk);
		end
		@(negedge ref_clk);
	endtask

	function automatic mit_row_s mk(mit_op_e op, logic e, ta, ui, pc, logic [2:0] b,
		logic [7:0] m, a0, f0, a1, f1, logic we, logic [7:0] wd, logic sk, int cyc);
		mit_row_s r;
		r.i = '0;
		r.i.op = op;
		r.i.ext = e;
		r.i.to_accum = ta;
		r.i.use_imm = ui;
		r.i.to_pcl = pc;
		r.i.bit_idx = b;
		r.i.mem_data = m;
		r.i.imm = m;
		r.i.addr = e ? 11'h5a3 : 11'h023;
		r.a0 = a0;
		r.f0 = f0;
		r.a1 = a1;
		r.f1 = f1;
		r.we = we;
		r.wd = wd;
		r.sk = sk;
		r.cyc = cyc;
		return r;
	endfunction

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (8) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(negedge ref_clk);
		chk({accumulator_reg, status_flags, table_pointer, table_high_byte}, 32'h0, "reset");
		chk({skip_pending, powerdown_mode, ins_ready}, 32'h1, "reset state");
		for (int a = 0; a < 6; a++)
		begin
			rd(8'(a * 4), v);
			chk(v, 32'h0, "register reset or unmapped");
		end
		wr(OFS_THIGH, 32'hff);
		rd(OFS_THIGH, v);
		chk(v, 32'h0, "read-only table high");
		wr(OFS_STATUS, 32'hff);
		rd(OFS_STATUS, v);
		chk(v, 32'hcf, "status read-only bits");
		$display("register test done");

		rows.push_back(mk(OP_MOVA, 0, 1, 0, 0, 0, 8'h5a, 8'h3c, 8'hcf, 8'h5a, 8'hcf, 0, 8'h00, 0, 1));
		rows.push_back(mk(OP_MOVA, 0, 1, 1, 0, 0, 8'h77, 8'h3c, 8'hcf, 8'h77, 8'hcf, 0, 8'h00, 0, 1));
		rows.push_back(mk(OP_MOVM, 0, 0, 0, 0, 0, 8'h11, 8'h3c, 8'hcf, 8'h3c, 8'hcf, 1, 8'h3c, 0, 1));
		rows.push_back(mk(OP_MOVM, 1, 0, 0, 0, 0, 8'h11, 8'h3c, 8'hcf, 8'h3c, 8'hcf, 1, 8'h3c, 0, 2));
		rows.push_back(mk(OP_MOVM, 0, 0, 0, 1, 0, 8'h11, 8'h3c, 8'hcf, 8'h3c, 8'hcf, 1, 8'h3c, 0, 2));
		rows.push_back(mk(OP_MOVM, 1, 0, 0, 1, 0, 8'h11, 8'h3c, 8'hcf, 8'h3c, 8'hcf, 1, 8'h3c, 0, 3));
		rows.push_back(mk(OP_BSET, 0, 0, 0, 0, 3, 8'h00, 8'h3c, 8'hcf, 8'h3c, 8'hcf, 1, 8'h08, 0, 1));
		rows.push_back(mk(OP_BCLR, 1, 0, 0, 0, 7, 8'hff, 8'h3c, 8'hcf, 8'h3c, 8'hcf, 1, 8'h7f, 0, 2));
		rows.push_back(mk(OP_RET_IMM, 0, 1, 1, 0, 0, 8'h99, 8'h3c, 8'hcf, 8'h99, 8'hcf, 0, 8'h00, 0, 2));
		for (mit_op_e o = OP_JMP; o <= OP_RET_INT; o = mit_op_e'(o + 1))
			rows.push_back(mk(o, 0, 0, 0, 0, 0, 8'h00, 8'h3c, 8'hcf, o == OP_RET_IMM ? 8'h00 : 8'h3c, 8'hcf, 0, 8'h00, 0, 2));
		rows.push_back(mk(OP_SWAP, 0, 0, 0, 0, 0, 8'ha5, 8'h3c, 8'hcf, 8'h3c, 8'hcf, 1, 8'h5a, 0, 1));
		rows.push_back(mk(OP_SWAP, 1, 1, 0, 0, 0, 8'ha5, 8'h3c, 8'hcf, 8'h5a, 8'hcf, 0, 8'h00, 0, 2));
		rows.push_back(mk(OP_SUB, 1, 1, 0, 0, 0, 8'h20, 8'h20, 8'h00, 8'h00, 8'h87, 0, 8'h00, 0, 2));
		rows.push_back(mk(OP_SUB, 0, 1, 0, 0, 0, 8'h30, 8'h20, 8'h00, 8'hf0, 8'h42, 0, 8'h00, 0, 1));
		rows.push_back(mk(OP_ADD, 0, 1, 0, 0, 0, 8'h20, 8'hf0, 8'h00, 8'h10, 8'h01, 0, 8'h00, 0, 1));
		rows.push_back(mk(OP_RRC, 0, 0, 0, 0, 0, 8'h01, 8'h3c, 8'h0e, 8'h3c, 8'h0f, 1, 8'h00, 0, 1));
		rows.push_back(mk(OP_RR, 0, 0, 0, 0, 0, 8'h01, 8'h3c, 8'h0e, 8'h3c, 8'h0e, 1, 8'h80, 0, 1));
		rows.push_back(mk(OP_RLC, 1, 1, 0, 0, 0, 8'h80, 8'h3c, 8'h00, 8'h00, 8'h01, 0, 8'h00, 0, 2));
		rows.push_back(mk(OP_DAA, 1, 0, 0, 0, 0, 8'h00, 8'h0a, 8'h0e, 8'h0a, 8'h0e, 1, 8'h10, 0, 2));
		rows.push_back(mk(OP_AND, 0, 1, 0, 0, 0, 8'h0f, 8'hf0, 8'hc3, 8'h00, 8'hc7, 0, 8'h00, 0, 1));
		rows.push_back(mk(OP_CPL, 1, 1, 0, 0, 0, 8'hff, 8'h3c, 8'hc3, 8'h00, 8'hc7, 0, 8'h00, 0, 2));
		rows.push_back(mk(OP_SZ, 0, 0, 0, 0, 0, 8'h00, 8'h3c, 8'hcb, 8'h3c, 8'hcb, 0, 8'h00, 1, 1));
		rows.push_back(mk(OP_SZ, 0, 0, 0, 0, 0, 8'h01, 8'h3c, 8'hcb, 8'h3c, 8'hcb, 0, 8'h00, 0, 1));
		rows.push_back(mk(OP_SNZ, 1, 0, 0, 0, 0, 8'h01, 8'h3c, 8'hcb, 8'h3c, 8'hcb, 0, 8'h00, 1, 2));
		rows.push_back(mk(OP_SZB, 0, 0, 0, 0, 2, 8'hfb, 8'h3c, 8'hcb, 8'h3c, 8'hcb, 0, 8'h00, 1, 1));
		rows.push_back(mk(OP_SNZB, 1, 0, 0, 0, 2, 8'h04, 8'h3c, 8'hcb, 8'h3c, 8'hcb, 0, 8'h00, 1, 2));
		rows.push_back(mk(OP_SIZ, 0, 1, 0, 0, 0, 8'hff, 8'h3c, 8'hcb, 8'h00, 8'hcb, 0, 8'h00, 1, 1));
		rows.push_back(mk(OP_SDZ, 1, 0, 0, 0, 0, 8'h01, 8'h3c, 8'hcb, 8'h3c, 8'hcb, 1, 8'h00, 1, 2));
		rows.push_back(mk(OP_SKZ_MOVE, 0, 0, 0, 0, 0, 8'h00, 8'h3c, 8'hcb, 8'h00, 8'hcb, 0, 8'h00, 1, 1));
		rows.push_back(mk(OP_SKZ_MOVE, 1, 0, 0, 0, 0, 8'h42, 8'h3c, 8'hcb, 8'h42, 8'hcb, 0, 8'h00, 0, 2));

		// Each row starts from its own accumulator and flags, then checks every result.
		foreach (rows[k])
		begin
			wr(OFS_ACCUM, {24'h0, rows[k].a0});
			wr(OFS_STATUS, {24'h0, rows[k].f0});
			n0 = wr_n;
			run(rows[k], n);
			chk(n, rows[k].cyc, "cycles");
			chk(accumulator_reg, rows[k].a1, "accumulator");
			chk(status_flags, rows[k].f1, "flags");
			chk(wr_n - n0, rows[k].we, "write count");
			if (rows[k].we)
				chk({wr_last.addr, wr_last.data}, {rows[k].i.addr, rows[k].wd}, "write");
			chk(skip_pending, rows[k].sk, "skip");
			if (rows[k].sk)
			begin
				n0 = wr_n;
				run(mk(OP_ADD, 1, 0, 0, 0, 0, 8'h11, 0, 0, 0, 0, 0, 0, 0, 0), n);
				chk(n, 2, "discard cycles");
				chk({accumulator_reg, status_flags}, {rows[k].a1, rows[k].f1}, "discard");
				chk({skip_pending, 8'(wr_n - n0)}, 0, "discard write");
			end
			$display("row %0d done", k);
		end

		// Every table read form, standard and extended, plain and last page.
		wr(OFS_TPTR, 32'h40);
		ptr = 8'h40;
		for (int k = 0; k < 8; k++)
		begin
			t = mk(OP_TBL_READ, k[2], 0, 0, 0, 0, 8'h00, 0, 0, 0, 0, 0, 0, 0, 0);
			t.i.last_page = k[1];
			t.i.preinc = k[0];
			ptr = ptr + 8'(k[0]);
			n0 = wr_n;
			run(t, n);
			chk(n, k[2] ? 3 : 2, "table cycles");
			chk({table_pointer, 8'(wr_n - n0), wr_last.data}, {ptr, 8'h01, ptr}, "table low");
			chk(table_high_byte, {1'b0, k[1] ? LAST_PAGE : cur_page}, "table high");
		end
		$display("table test done");

		// Halt, wake by register, then watchdog clear.
		run(mk(OP_HALT, 0, 0, 0, 0, 0, 8'h00, 0, 0, 0, 0, 0, 0, 0, 0), n);
		chk({powerdown_mode, ins_ready}, 2'b10, "asleep");
		chk({status_flags.timeout_flag, status_flags.powerdown_flag}, 2'b01, "halt flags");
		wr(OFS_STATE, 32'h4);
		@(negedge ref_clk);
		chk({powerdown_mode, ins_ready}, 2'b01, "awake");
		wr(OFS_STATUS, 32'hff);
		@(negedge ref_clk);
		chk(status_flags, 8'hdf, "flags kept");
		run(mk(OP_WDT_CLR, 0, 0, 0, 0, 0, 8'h00, 0, 0, 0, 0, 0, 0, 0, 0), n);
		chk(n, 1, "watchdog cycles");
		chk(status_flags, 8'hcf, "watchdog flags");
		$display("power test done");
		conclude();
	end
endmodule
`default_nettype wire

// >>> tb/mit_pm_model.sv
// Program memory model that answers table reads for the timing unit bench.
`timescale 1ns/1ps
`default_nettype none

module mit_pm_model
	import mit_pkg::*;
(
	input  wire logic             ref_clk,  // Instruction clock.
	input  wire logic             pm_rd,    // Read pulse from the core.
	input  wire logic [PM_AW-1:0] pm_addr,  // Word address from the core.
	output var  logic [15:0]      pm_data   // Word, valid while the pulse stands.
);
	logic [15:0] idle_q = 16'h0000;

	// The word carries the page in its high byte and the pointer in its low byte.
	// It is answered while the pulse stands, since the core takes it at the pulse's last edge.
	// Outside the pulse the bus toggles, so a late capture cannot match by luck.
	always @(posedge ref_clk)
		idle_q <= ~idle_q;
	assign pm_data = pm_rd ? {1'b0, pm_addr} : idle_q;
endmodule
`default_nettype wire
